// [logic/pscd_pkg.sv]
// Constants and types shared by the strap configuration decoder.
package pscd_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PSCD_OFF_STRAP = 8'h00;
  localparam logic [7:0] PSCD_OFF_CFG = 8'h04;
  localparam logic [7:0] PSCD_OFF_CHAN = 8'h08;
  localparam logic [7:0] PSCD_OFF_PROG = 8'h0C;
  localparam logic [7:0] PSCD_OFF_STAT = 8'h10;
  localparam logic [7:0] PSCD_OFF_MASK = 8'h14;
  localparam logic [1:0] PSCD_RESP_OK = 2'h0;
  localparam logic [1:0] PSCD_RESP_ERR = 2'h2;

  // ---------------------------------------------------------------
  // Strap vector layout and default levels
  // ---------------------------------------------------------------
  localparam int PSCD_STRAP_W = 16;
  localparam int PSCD_B_RES = 12;
  localparam int PSCD_B_FMT = 11;
  localparam int PSCD_B_RELOAD = 10;
  localparam int PSCD_B_SRC = 9;
  localparam int PSCD_B_GATE_SUP = 8;
  localparam int PSCD_B_GMODE = 7;
  localparam int PSCD_B_GPOS = 5;
  localparam int PSCD_B_COUNT = 3;
  localparam int PSCD_B_WBID = 2;
  localparam int PSCD_B_CID = 0;
  localparam logic [15:0] PSCD_STRAP_RST = 16'h2804;

  // ---------------------------------------------------------------
  // Codes, counts and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] PSCD_RES_DEFAULT = 4'h2;
  localparam logic [3:0] PSCD_RES_LAST_FIXED = 4'hC;
  localparam logic [3:0] PSCD_RES_PROG = 4'hF;
  localparam logic [1:0] PSCD_CID_MASTER = 2'h0;
  localparam logic [1:0] PSCD_CID_RSV = 2'h3;
  localparam logic [4:0] PSCD_FRAME_LAST = 5'h1D;
  localparam logic [26:0] PSCD_PROG_RST = 27'h2D00780;
  localparam logic [10:0] PSCD_CH_FULL = 11'h780;
  localparam int PSCD_IRQ_W = 3;
  localparam int PSCD_IRQ_RELOAD = 0;
  localparam int PSCD_IRQ_ERR = 1;
  localparam int PSCD_IRQ_FALLBACK = 2;
  localparam logic [2:0] PSCD_MASK_RST = 3'h0;

  // ---------------------------------------------------------------
  // Fixed resolution and channel tables, entry 12 first
  // ---------------------------------------------------------------
  localparam logic [12:0][10:0] PSCD_H_TBL = {11'h21C, 11'h258, 11'h280, 11'h3C0, 11'h400, 11'h400,
    11'h400, 11'h500, 11'h500, 11'h500, 11'h780, 11'h780, 11'h780};
  localparam logic [12:0][10:0] PSCD_V_TBL = {11'h3C0, 11'h400, 11'h1E0, 11'h21C, 11'h1E0, 11'h258,
    11'h300, 11'h1E0, 11'h2D0, 11'h320, 11'h2D0, 11'h438, 11'h4B0};
  localparam logic [12:0][10:0] PSCD_CH_TBL = {11'h654, 11'h708, 11'h780, 11'h5A0, 11'h600, 11'h600,
    11'h600, 11'h780, 11'h780, 11'h780, 11'h780, 11'h780, 11'h780};
  localparam logic [12:0][10:0] PSCD_DLO_TBL = {11'h331, 11'h385, 11'h000, 11'h2D1, 11'h301, 11'h301,
    11'h301, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000};
  localparam logic [12:0][10:0] PSCD_DHI_TBL = {11'h45C, 11'h3FC, 11'h000, 11'h4B0, 11'h480, 11'h480,
    11'h480, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000};

  typedef enum logic [1:0] {
    PSCD_GPOS_LEFT,
    PSCD_GPOS_RIGHT,
    PSCD_GPOS_INTERLACE,
    PSCD_GPOS_PROGRESSIVE
  } pscd_gpos_t;

endpackage

// [logic/pscd_sync.sv]
// Two-stage synchroniser bank for the strap pins.
`timescale 1ns/10ps
module pscd_sync #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // One pair of flip-flops per bit
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      meta_q[i] <= async_in[i];
      sync_out[i] <= meta_q[i];
    end
  end

endmodule // pscd_sync

// [logic/pscd_top.sv]
// Strap capture and decode with AXI4-Lite status, interrupt and cascade access gating.
//
// Overview of operation
// [R1] Code 0010 gives 1920x720 default timing.
// [R2] Thirteen fixed codes, two reserved, one programmable.
// [R3] Board avoids codes unsupported by input interface.
// [R4] Code selects active channels and blanked range.
// [R5] Format strap high first, low alternative.
// [R6] Reload strap high: reload every 30 frames.
// [R7] Source supply strap high external, low internal.
// [R8] Gate supply strap high external, low pumps.
// [R9] Gate mode strap high external driver, low GIP.
// [R10] Gate position: left, right, interlace, progressive.
// [R11] Chip count: 3, 1, 2, 4.
// [R12] Error output low while any error present.
// [R13] Write-by-ID high, identity 00 answers reads.
// [R14] Writes filtered by identity; reads master only.
// [R15] Identity: master, slave one, slave two, reserved.
// [R16] Capture straps in reset, hold, default levels.
// [R17] Reserved resolution or identity falls back default.
`timescale 1ns/10ps
module pscd_top
  import pscd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] resolution_strap,
  input wire logic lvds_format_strap,
  input wire logic nvm_auto_reload_strap,
  input wire logic source_supply_select_strap,
  input wire logic gate_supply_select_strap,
  input wire logic gate_mode_strap,
  input wire logic [1:0] gate_position_strap,
  input wire logic [1:0] chip_count_strap,
  input wire logic write_by_id_strap,
  input wire logic [1:0] chip_identity_strap,
  input wire logic frame_start,
  input wire logic [3:0] err_cond,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_id,
  output logic [3:0] res_code_q,
  output logic [10:0] h_active_q,
  output logic [10:0] v_active_q,
  output logic [10:0] chan_total_q,
  output logic [10:0] dis_lo_q,
  output logic [10:0] dis_hi_q,
  output logic lvds_fmt_alt_q,
  output logic ext_src_supply_q,
  output logic int_src_gen_en_q,
  output logic ext_gate_supply_q,
  output logic int_gate_pump_en_q,
  output logic gate_drv_ext_q,
  output pscd_gpos_t gate_pos_q,
  output logic [2:0] chip_count_q,
  output logic [1:0] chip_id_q,
  output logic otp_reload_q,
  output logic err_n_q,
  output logic acc_accept_q,
  output logic acc_rd_answer_q,
  output logic irq_q,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready_q,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready_q,
  output logic [1:0] s_axi_bresp_q,
  output logic s_axi_bvalid_q,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready_q,
  output logic [31:0] s_axi_rdata_q,
  output logic [1:0] s_axi_rresp_q,
  output logic s_axi_rvalid_q,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // Strap synchronisation and capture
  // ---------------------------------------------------------------
  logic [15:0] strap_sync;
  logic [15:0] strap_q;
  logic cfg_valid_q;

  pscd_sync #(.W(PSCD_STRAP_W)) u_sync (
    .aclk(aclk),
    .async_in({resolution_strap, lvds_format_strap, nvm_auto_reload_strap, source_supply_select_strap,
      gate_supply_select_strap, gate_mode_strap, gate_position_strap, chip_count_strap,
      write_by_id_strap, chip_identity_strap}),
    .sync_out(strap_sync)
  );

  // Reset must last at least three edges so the capture sees settled pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= strap_sync; // [R16]
      cfg_valid_q <= 1'b0;
    end else begin
      cfg_valid_q <= 1'b1;
    end
  end

  logic [3:0] s_res;
  logic [1:0] s_cid;
  logic [1:0] s_cnt;
  logic s_wbid;
  logic res_rsv;
  logic cid_rsv;
  logic [3:0] res_eff;
  logic [1:0] cid_eff;
  logic [26:0] prog_q;

  assign s_res = strap_q[PSCD_B_RES +: 4];
  assign s_cid = strap_q[PSCD_B_CID +: 2];
  assign s_cnt = strap_q[PSCD_B_COUNT +: 2];
  assign s_wbid = strap_q[PSCD_B_WBID];
  assign res_rsv = (s_res > PSCD_RES_LAST_FIXED) && (s_res != PSCD_RES_PROG);
  assign cid_rsv = (s_cid == PSCD_CID_RSV);
  assign res_eff = res_rsv ? PSCD_RES_DEFAULT : s_res; // [R17]
  assign cid_eff = cid_rsv ? PSCD_CID_MASTER : s_cid; // [R17] [R15]

  // ---------------------------------------------------------------
  // Decoded settings
  // ---------------------------------------------------------------
  // Channel blanking is the same on every chip position for the fixed codes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_code_q <= PSCD_RES_DEFAULT;
      h_active_q <= PSCD_H_TBL[PSCD_RES_DEFAULT];
      v_active_q <= PSCD_V_TBL[PSCD_RES_DEFAULT];
      chan_total_q <= PSCD_CH_FULL;
      dis_lo_q <= '0;
      dis_hi_q <= '0;
    end else if (res_eff == PSCD_RES_PROG) begin
      res_code_q <= res_eff; // [R2]
      h_active_q <= prog_q[10:0];
      v_active_q <= prog_q[26:16];
      chan_total_q <= PSCD_CH_FULL;
      dis_lo_q <= '0;
      dis_hi_q <= '0;
    end else begin
      res_code_q <= res_eff; // [R1] [R2]
      h_active_q <= PSCD_H_TBL[res_eff];
      v_active_q <= PSCD_V_TBL[res_eff];
      chan_total_q <= PSCD_CH_TBL[res_eff]; // [R4]
      dis_lo_q <= PSCD_DLO_TBL[res_eff];
      dis_hi_q <= PSCD_DHI_TBL[res_eff];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvds_fmt_alt_q <= 1'b0;
      ext_src_supply_q <= 1'b0;
      int_src_gen_en_q <= 1'b1;
      ext_gate_supply_q <= 1'b0;
      int_gate_pump_en_q <= 1'b1;
      gate_drv_ext_q <= 1'b0;
      gate_pos_q <= PSCD_GPOS_LEFT;
      chip_count_q <= 3'h3;
      chip_id_q <= PSCD_CID_MASTER;
    end else begin
      lvds_fmt_alt_q <= !strap_q[PSCD_B_FMT]; // [R5]
      ext_src_supply_q <= strap_q[PSCD_B_SRC]; // [R7]
      int_src_gen_en_q <= !strap_q[PSCD_B_SRC];
      ext_gate_supply_q <= strap_q[PSCD_B_GATE_SUP]; // [R8]
      int_gate_pump_en_q <= !strap_q[PSCD_B_GATE_SUP];
      gate_drv_ext_q <= strap_q[PSCD_B_GMODE]; // [R9]
      gate_pos_q <= pscd_gpos_t'(strap_q[PSCD_B_GPOS +: 2]); // [R10]
      chip_id_q <= cid_eff;
      case (s_cnt) // [R11]
        2'h0: chip_count_q <= 3'h3;
        2'h1: chip_count_q <= 3'h1;
        2'h2: chip_count_q <= 3'h2;
        default: chip_count_q <= 3'h4;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Cascade register access gating
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_accept_q <= 1'b0;
      acc_rd_answer_q <= 1'b0;
    end else begin
      acc_accept_q <= acc_valid && acc_write && (!s_wbid || acc_id == cid_eff); // [R14]
      acc_rd_answer_q <= acc_valid && !acc_write && cid_eff == PSCD_CID_MASTER &&
        (!s_wbid || acc_id == PSCD_CID_MASTER); // [R13] [R14]
    end
  end

  // ---------------------------------------------------------------
  // Periodic reload and error pin
  // ---------------------------------------------------------------
  logic [4:0] frame_cnt_q;
  logic err_any;
  logic err_any_q;
  logic reload_fire;

  assign err_any = |err_cond;
  assign reload_fire = frame_start && strap_q[PSCD_B_RELOAD] && frame_cnt_q == PSCD_FRAME_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn || !strap_q[PSCD_B_RELOAD]) begin
      frame_cnt_q <= '0;
      otp_reload_q <= 1'b0;
    end else begin
      otp_reload_q <= reload_fire; // [R6]
      if (frame_start) begin
        frame_cnt_q <= reload_fire ? 5'h00 : frame_cnt_q + 5'h01;
      end
    end
  end

  // An external pull-up may hold the line high; the driven level is high whenever no error is present.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_n_q <= 1'b1;
      err_any_q <= 1'b0;
    end else begin
      err_n_q <= !err_any; // [R12]
      err_any_q <= err_any;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [2:0] sts_q;
  logic [2:0] mask_q;
  logic [2:0] sts_set;
  logic [2:0] sts_clr;
  logic wr_do;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic [31:0] wr_bits;

  assign wr_bits = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}}, {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
  assign sts_set[PSCD_IRQ_RELOAD] = reload_fire;
  assign sts_set[PSCD_IRQ_ERR] = err_any && !err_any_q;
  assign sts_set[PSCD_IRQ_FALLBACK] = !cfg_valid_q && aresetn && (res_rsv || cid_rsv);
  assign sts_clr = (wr_do && wr_addr_q == PSCD_OFF_STAT) ? (wr_data_q[2:0] & wr_bits[2:0]) : 3'h0;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
      irq_q <= |(((sts_q & ~sts_clr) | sts_set) & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic aw_hs;
  logic w_hs;
  logic aw_hold_q;
  logic w_hold_q;
  logic aw_hold_d;
  logic w_hold_d;
  logic bvalid_d;
  logic wr_hit;

  assign aw_hs = s_axi_awvalid && s_axi_awready_q;
  assign w_hs = s_axi_wvalid && s_axi_wready_q;
  assign wr_do = aw_hold_q && w_hold_q && !s_axi_bvalid_q;
  assign aw_hold_d = (aw_hold_q && !wr_do) || aw_hs;
  assign w_hold_d = (w_hold_q && !wr_do) || w_hs;
  assign bvalid_d = (s_axi_bvalid_q && !s_axi_bready) || wr_do;
  assign wr_hit = wr_addr_q == PSCD_OFF_PROG || wr_addr_q == PSCD_OFF_STAT || wr_addr_q == PSCD_OFF_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      s_axi_awready_q <= 1'b0;
      s_axi_wready_q <= 1'b0;
      s_axi_bvalid_q <= 1'b0;
      s_axi_bresp_q <= PSCD_RESP_OK;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      s_axi_awready_q <= !aw_hold_d && !bvalid_d;
      s_axi_wready_q <= !w_hold_d && !bvalid_d;
      s_axi_bvalid_q <= bvalid_d;
      if (aw_hs) begin
        wr_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_hs) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bresp_q <= wr_hit ? PSCD_RESP_OK : PSCD_RESP_ERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_q <= PSCD_PROG_RST;
      mask_q <= PSCD_MASK_RST;
    end else if (wr_do) begin
      if (wr_addr_q == PSCD_OFF_PROG) begin
        prog_q <= (prog_q & ~wr_bits[26:0]) | (wr_data_q[26:0] & wr_bits[26:0]);
      end
      if (wr_addr_q == PSCD_OFF_MASK) begin
        mask_q <= (mask_q & ~wr_bits[2:0]) | (wr_data_q[2:0] & wr_bits[2:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic ar_hs;
  logic rvalid_d;
  logic [31:0] rd_mux;

  assign ar_hs = s_axi_arvalid && s_axi_arready_q;
  assign rvalid_d = (s_axi_rvalid_q && !s_axi_rready) || ar_hs;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      PSCD_OFF_STRAP: rd_mux = {16'h0000, strap_q};
      PSCD_OFF_CFG: rd_mux = {15'h0000, chip_id_q, chip_count_q, gate_pos_q, gate_drv_ext_q,
        ext_gate_supply_q, ext_src_supply_q, otp_reload_q, lvds_fmt_alt_q, !err_n_q, res_code_q};
      PSCD_OFF_CHAN: rd_mux = {10'h000, dis_hi_q, dis_lo_q};
      PSCD_OFF_PROG: rd_mux = {5'h00, prog_q};
      PSCD_OFF_STAT: rd_mux = {29'h0000_0000, sts_q};
      PSCD_OFF_MASK: rd_mux = {29'h0000_0000, mask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready_q <= 1'b0;
      s_axi_rvalid_q <= 1'b0;
      s_axi_rdata_q <= '0;
      s_axi_rresp_q <= PSCD_RESP_OK;
    end else begin
      s_axi_arready_q <= !rvalid_d;
      s_axi_rvalid_q <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata_q <= rd_mux;
        s_axi_rresp_q <= (s_axi_araddr[7:2] <= PSCD_OFF_MASK[7:2]) ? PSCD_RESP_OK : PSCD_RESP_ERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DEFAULT_RES: assert property (cfg_valid_q && s_res == PSCD_RES_DEFAULT |-> // [R1]
    h_active_q == 11'h780 && v_active_q == 11'h2D0) else $error("default resolution wrong");
  AST_RES_FALLBACK: assert property (cfg_valid_q && res_rsv |-> // [R17]
    res_code_q == PSCD_RES_DEFAULT && chan_total_q == PSCD_CH_FULL) else $error("reserved code not defaulted");
  AST_CHAN_BLANK: assert property (cfg_valid_q && s_res == 4'h6 |-> // [R4]
    chan_total_q == 11'h600 && dis_lo_q == 11'h301 && dis_hi_q == 11'h480) else $error("channel blank wrong");
  AST_RELOAD_OFF: assert property (!strap_q[PSCD_B_RELOAD] |=> !otp_reload_q) // [R6]
    else $error("reload while disabled");
  AST_RELOAD_PERIOD: assert property (otp_reload_q |-> $past(frame_start) && // [R6]
    $past(frame_cnt_q) == PSCD_FRAME_LAST) else $error("reload not on thirtieth frame");
  AST_SUPPLY: assert property (cfg_valid_q |-> ext_src_supply_q != int_src_gen_en_q && // [R7]
    ext_gate_supply_q != int_gate_pump_en_q) else $error("supply select inconsistent");
  AST_COUNT: assert property (cfg_valid_q && s_cnt == 2'h0 |-> chip_count_q == 3'h3) // [R11]
    else $error("chip count default wrong");
  AST_ERR_PIN: assert property (err_any |=> !err_n_q ##1 ($past(err_any) || err_n_q)) // [R12]
    else $error("error pin not following condition");
  AST_STABLE: assert property (cfg_valid_q ##1 cfg_valid_q |-> // [R16]
    $stable(res_code_q) && $stable(gate_pos_q) && $stable(chip_id_q)) else $error("settings moved");
  AST_WR_BY_ID: assert property (acc_valid && acc_write && s_wbid && acc_id != cid_eff |=> // [R14]
    !acc_accept_q) else $error("foreign write accepted");
  AST_RD_MASTER: assert property (acc_valid && !acc_write && cid_eff != PSCD_CID_MASTER |=> // [R13]
    !acc_rd_answer_q) else $error("slave answered read");
  AST_CID_RSV: assert property (cfg_valid_q && cid_rsv |-> chip_id_q == PSCD_CID_MASTER) // [R15]
    else $error("reserved identity kept");

  COV_RELOAD: cover property (otp_reload_q);
  COV_ERR: cover property (err_any ##1 !err_n_q ##[1:20] err_n_q);
  COV_ACC: cover property (acc_valid && acc_write ##1 acc_accept_q);

endmodule // pscd_top

// [tb/pscd_board_model.sv]
// Board model: static strap levels and requests from cascaded companion chips.
`timescale 1ns/10ps
module pscd_board_model (
  input wire logic aclk,
  input wire logic [15:0] strap_vec,
  output logic [3:0] resolution_strap,
  output logic lvds_format_strap,
  output logic nvm_auto_reload_strap,
  output logic source_supply_select_strap,
  output logic gate_supply_select_strap,
  output logic gate_mode_strap,
  output logic [1:0] gate_position_strap,
  output logic [1:0] chip_count_strap,
  output logic write_by_id_strap,
  output logic [1:0] chip_identity_strap,
  output logic acc_valid,
  output logic acc_write,
  output logic [1:0] acc_id
);
  // The board ties whatever levels strap_vec carries, reserved codes included, and tied levels never move by themselves.
  assign {resolution_strap, lvds_format_strap, nvm_auto_reload_strap, source_supply_select_strap,
    gate_supply_select_strap, gate_mode_strap, gate_position_strap, chip_count_strap, write_by_id_strap,
    chip_identity_strap} = strap_vec;
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_id = 2'h0;
  end
  // Released qualifiers are inverted so that a stale value is never mistaken for a live one.
  task automatic send(input logic w, input logic [1:0] id);
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_id <= id;
    @(posedge aclk);
    acc_valid <= 1'b0;
    acc_write <= ~w;
    acc_id <= ~id;
  endtask
endmodule // pscd_board_model

// [tb/tb_panel_strap_config_decoder.sv]
// Self-checking testbench of the strap configuration decoder.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_panel_strap_config_decoder;
  import pscd_pkg::*;
  // ----
  // Signals
  // ----
  logic aclk = 0, aresetn = 0, frame_start = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [15:0] strap_vec = PSCD_STRAP_RST;
  logic [3:0] err_cond = 4'h0, wstrb = 4'hF, res_code_q;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [10:0] h_active_q, v_active_q, chan_total_q, dis_lo_q, dis_hi_q;
  logic lvds_fmt_alt_q, ext_src_supply_q, int_src_gen_en_q, ext_gate_supply_q, int_gate_pump_en_q, gate_drv_ext_q;
  logic otp_reload_q, err_n_q, acc_accept_q, acc_rd_answer_q, irq_q, awready, wready, bvalid, arready, rvalid;
  pscd_gpos_t gate_pos_q;
  logic [2:0] chip_count_q;
  logic [1:0] chip_id_q, bresp, rresp, rsp;
  wire [3:0] res_s;
  wire fmt_s, rld_s, src_s, gsup_s, gmode_s, wbid_s, acc_valid, acc_write;
  wire [1:0] gpos_s, cnt_s, cid_s, acc_id;
  int miscompares = 0, n_compared = 0, n_acc = 0, n_ans = 0, n_rld = 0;
  logic [3:0] rc[4] = '{4'h6, 4'h9, 4'hD, 4'hF};
  logic [3:0] erc[4] = '{4'h6, 4'h9, 4'h2, 4'hF};
  logic [10:0] eh[4] = '{11'h400, 11'h3C0, 11'h780, 11'h780};
  logic [10:0] ev[4] = '{11'h300, 11'h21C, 11'h2D0, 11'h2D0};
  logic [10:0] ech[4] = '{11'h600, 11'h5A0, 11'h780, 11'h780};
  logic [10:0] elo[4] = '{11'h301, 11'h2D1, 11'h000, 11'h000};
  logic [10:0] ehi[4] = '{11'h480, 11'h4B0, 11'h000, 11'h000};
  logic [2:0] ecnt[4] = '{3'h3, 3'h1, 3'h2, 3'h4};

  always #20 aclk = ~aclk;

  pscd_board_model board (.aclk(aclk), .strap_vec(strap_vec), .resolution_strap(res_s), .lvds_format_strap(fmt_s),
    .nvm_auto_reload_strap(rld_s), .source_supply_select_strap(src_s), .gate_supply_select_strap(gsup_s),
    .gate_mode_strap(gmode_s), .gate_position_strap(gpos_s), .chip_count_strap(cnt_s),
    .write_by_id_strap(wbid_s), .chip_identity_strap(cid_s), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_id(acc_id));

  pscd_top dut (.aclk(aclk), .aresetn(aresetn), .resolution_strap(res_s), .lvds_format_strap(fmt_s),
    .nvm_auto_reload_strap(rld_s), .source_supply_select_strap(src_s), .gate_supply_select_strap(gsup_s),
    .gate_mode_strap(gmode_s), .gate_position_strap(gpos_s), .chip_count_strap(cnt_s),
    .write_by_id_strap(wbid_s), .chip_identity_strap(cid_s), .frame_start(frame_start), .err_cond(err_cond),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_id(acc_id), .res_code_q(res_code_q),
    .h_active_q(h_active_q), .v_active_q(v_active_q), .chan_total_q(chan_total_q), .dis_lo_q(dis_lo_q),
    .dis_hi_q(dis_hi_q), .lvds_fmt_alt_q(lvds_fmt_alt_q), .ext_src_supply_q(ext_src_supply_q),
    .int_src_gen_en_q(int_src_gen_en_q), .ext_gate_supply_q(ext_gate_supply_q),
    .int_gate_pump_en_q(int_gate_pump_en_q), .gate_drv_ext_q(gate_drv_ext_q), .gate_pos_q(gate_pos_q),
    .chip_count_q(chip_count_q), .chip_id_q(chip_id_q), .otp_reload_q(otp_reload_q), .err_n_q(err_n_q),
    .acc_accept_q(acc_accept_q), .acc_rd_answer_q(acc_rd_answer_q), .irq_q(irq_q), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready_q(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready_q(wready), .s_axi_bresp_q(bresp), .s_axi_bvalid_q(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready_q(arready),
    .s_axi_rdata_q(rdata), .s_axi_rresp_q(rresp), .s_axi_rvalid_q(rvalid), .s_axi_rready(rready));

  // Pulses are counted here so that a task never has to catch a one-cycle output in flight.
  always @(posedge aclk) begin
    if (acc_accept_q === 1'b1) n_acc++;
    if (acc_rd_answer_q === 1'b1) n_ans++;
    if (otp_reload_q === 1'b1) n_rld++;
  end

  // ----
  // Bus and stimulus tasks
  // ----
  task automatic do_reset(input logic [15:0] v);
    @(posedge aclk);
    strap_vec <= v;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic frames(input int k);
    repeat (k) begin
      @(posedge aclk);
      frame_start <= 1'b1;
      @(posedge aclk);
      frame_start <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask

  task automatic casc(input logic w, input logic [1:0] id, input int e);
    int a0, b0;
    a0 = n_acc;
    b0 = n_ans;
    board.send(w, id);
    repeat (3) @(posedge aclk);
    if (w) `CHK(n_acc - a0, e) else `CHK(n_ans - b0, e)
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_decode();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {rc[i], i[0], 1'b0, i[0], i[1], ~i[0], i[1:0], i[1:0], i[0], i[1:0]};
      do_reset(v);
      `CHK(res_code_q, erc[i])
      `CHK({h_active_q, v_active_q}, {eh[i], ev[i]})
      `CHK({chan_total_q, dis_lo_q, dis_hi_q}, {ech[i], elo[i], ehi[i]})
      `CHK({lvds_fmt_alt_q, ext_src_supply_q, int_src_gen_en_q}, {~i[0], i[0], ~i[0]})
      `CHK({ext_gate_supply_q, int_gate_pump_en_q, gate_drv_ext_q}, {i[1], ~i[1], ~i[0]})
      `CHK({gate_pos_q, chip_count_q}, {i[1:0], ecnt[i]})
      `CHK(chip_id_q, (i == 3) ? 2'h0 : i[1:0])
      axi_rd(PSCD_OFF_STRAP, rd, rsp);
      `CHK(rd[15:0], v)
      axi_rd(PSCD_OFF_STAT, rd, rsp);
      `CHK(rd[2], i >= 2)
      strap_vec <= ~v;
      repeat (4) @(posedge aclk);
      `CHK({res_code_q, chip_id_q}, {erc[i], ((i == 3) ? 2'h0 : i[1:0])})
    end
    $display("test decode done");
  endtask

  task automatic t_regs();
    do_reset(PSCD_STRAP_RST);
    axi_rd(PSCD_OFF_MASK, rd, rsp);
    `CHK(rd[2:0], PSCD_MASK_RST)
    axi_rd(PSCD_OFF_PROG, rd, rsp);
    `CHK(rd[26:0], PSCD_PROG_RST)
    axi_wr(PSCD_OFF_PROG, 32'h01E00280, rsp);
    axi_rd(PSCD_OFF_PROG, rd, rsp);
    `CHK(rd, 32'h01E00280)
    axi_wr(PSCD_OFF_MASK, 32'h2, rsp);
    err_cond <= 4'h4;
    repeat (4) @(posedge aclk);
    `CHK({err_n_q, irq_q}, 2'b01)
    axi_rd(PSCD_OFF_CFG, rd, rsp);
    `CHK(rd[4], 1'b1)
    err_cond <= 4'h0;
    repeat (4) @(posedge aclk);
    `CHK({err_n_q, irq_q}, 2'b11)
    axi_wr(PSCD_OFF_STAT, 32'h2, rsp);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    axi_wr(PSCD_OFF_MASK, 32'h0, rsp);
    err_cond <= 4'h1;
    repeat (4) @(posedge aclk);
    `CHK({err_n_q, irq_q}, 2'b00)
    err_cond <= 4'h0;
    axi_rd(8'h18, rd, rsp);
    `CHK({rsp, rd}, {PSCD_RESP_ERR, 32'h0})
    axi_wr(8'h18, 32'h1, rsp);
    `CHK(rsp, PSCD_RESP_ERR)
    axi_wr(PSCD_OFF_STRAP, 32'h0, rsp);
    axi_rd(PSCD_OFF_STRAP, rd, rsp);
    `CHK(rd[15:0], PSCD_STRAP_RST)
    $display("test registers done");
  endtask

  task automatic t_reload();
    do_reset(PSCD_STRAP_RST);
    n_rld = 0;
    frames(30);
    `CHK(n_rld, 0)
    do_reset(PSCD_STRAP_RST | 16'h0400);
    n_rld = 0;
    frames(29);
    `CHK(n_rld, 0)
    frames(1);
    repeat (3) @(posedge aclk);
    `CHK(n_rld, 1)
    axi_rd(PSCD_OFF_STAT, rd, rsp);
    `CHK(rd[0], 1'b1)
    $display("test reload done");
  endtask

  task automatic t_casc();
    do_reset(PSCD_STRAP_RST);
    casc(1'b1, 2'h0, 1);
    casc(1'b1, 2'h1, 0);
    casc(1'b0, 2'h0, 1);
    casc(1'b0, 2'h1, 0);
    do_reset(16'h2801);
    casc(1'b1, 2'h2, 1);
    casc(1'b0, 2'h0, 0);
    do_reset(16'h2800);
    casc(1'b0, 2'h3, 1);
    $display("test cascade done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(PSCD_STRAP_RST);
    t_decode();
    t_regs();
    t_reload();
    t_casc();
    print_verdict();
  end

  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_panel_strap_config_decoder
